// *** sbm_station_bus_master.sv ***
`default_nettype none
// Behaviour
// - Nibble bus: sixteen 4-bit nibbles, 64 bits, one per address value.
// - Nibble address advances by one, wrapping modulo 16.
// - Nibble data travels on four active-low lines during its address.
// - Service interrupt to processor pulses low at every address step.
// - Data strobe is the bus clock divided by 640; timing follows it.
// - This block alone drives nibble address, strobe and timing.
// - Shared serial line runs at 1200 baud.
// - Serial line idles high via pull-up; driven only while writing.
// - Transmit and receive share one line; own transmission is received.
// - A 40-bit packet circulates continuously with no gaps.
// - Block writes only its 16 ring bits; all 40 bits readable.
// - Block is ring master, driving bit clock and frame sync.
// - Ring bit clock square, one period per bit, default bus clock / 2.
// - Frame sync lasts exactly one bit time at packet start.
// - Ring out goes to trunking controller; loop returns on ring in.
// - Bus clock is crystal divided by four; this clock is the bus clock.
module sbm_station_bus_master #(
    parameter int unsigned STROBE_DIV = sbm_pkg::STROBE_DIV,
    parameter int unsigned BAUD_DIV = sbm_pkg::BAUD_DIV,
    parameter int unsigned RING_BITS = sbm_pkg::RING_BITS
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Nibble bus.
    output logic [3:0] o_nibble_address,
    output logic o_nibble_strobe_n,
    output logic o_nibble_service_irq_n,
    input wire logic [3:0] i_nibble_data_n,
    output logic [3:0] o_nibble_data_n,
    output logic [3:0] o_nibble_data_oe_n,
    input wire logic [3:0] i_nibble_wr_data,
    input wire logic [3:0] i_nibble_wr_en,
    output logic [3:0] o_nibble_rd_data,
    // Shared serial line, open-drain style.
    input wire logic i_serial_line,
    output logic o_serial_line,
    output logic o_serial_line_oe_n,
    input wire logic i_tx_bit,
    input wire logic i_tx_active,
    output logic o_rx_bit,
    output logic o_baud_tick,
    // Circulating ring.
    input wire logic [7:0] i_ring_half_period,
    input wire logic [15:0] i_ring_own_bits,
    output logic o_ring_bit_clock,
    output logic o_ring_frame_sync,
    output logic o_ring_data_out,
    input wire logic i_ring_data_in,
    output logic [39:0] o_ring_packet,
    output logic o_ring_packet_valid
);
    // Dividers are 16 bits wide and the ring index logic is sized for a 40-bit packet.
    if (STROBE_DIV < 2 || STROBE_DIV > 65536 || BAUD_DIV < 1 || BAUD_DIV > 65536 ||
            RING_BITS != sbm_pkg::RING_BITS) begin : g_bad_params
        $error("sbm_station_bus_master: unsupported parameter values");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Nibble bus strobe and address scan.
    logic [15:0] sdiv_r;
    logic [15:0] sdiv_nxt;
    logic [3:0] addr_r;
    logic [3:0] addr_nxt;
    logic strobe_n_r;
    logic strobe_n_nxt;
    logic irq_n_r;
    logic irq_n_nxt;
    logic [3:0] rd_r;
    logic [3:0] rd_nxt;
    logic step;

    // Strobe is low for the second half of each 640-clock period; the address
    // steps on the rising edge so it stays put for a whole strobe period.
    always_comb begin
        step = (sdiv_r == 16'(STROBE_DIV - 1));
        sdiv_nxt = step ? 16'h0000 : sdiv_r + 16'h0001;
        strobe_n_nxt = (sdiv_nxt < 16'(STROBE_DIV / 2));
        addr_nxt = step ? addr_r + 4'h1 : addr_r;
        irq_n_nxt = ~step;
        rd_nxt = (step) ? ~i_nibble_data_n : rd_r;
    end

    // All timing counts cycles of this clock, which is the bus clock itself.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            sdiv_r <= 16'h0000;
            addr_r <= sbm_pkg::NIBBLE_ADDR_RESET;
            strobe_n_r <= 1'b1;
            irq_n_r <= 1'b1;
            rd_r <= 4'h0;
        end else begin
            sdiv_r <= sdiv_nxt;
            addr_r <= addr_nxt;
            strobe_n_r <= strobe_n_nxt;
            irq_n_r <= irq_n_nxt;
            rd_r <= rd_nxt;
        end
    end

    // Address, strobe and interrupt come from flops, so slaves never see glitches.
    assign o_nibble_address = addr_r;
    assign o_nibble_strobe_n = strobe_n_r;
    assign o_nibble_service_irq_n = irq_n_r;
    assign o_nibble_rd_data = rd_r; // Data captured for the nibble just left.
    // Open-drain nibble lines: only a set bit pulls its line low.
    assign o_nibble_data_n = 4'h0;
    assign o_nibble_data_oe_n = ~(i_nibble_wr_data & i_nibble_wr_en);

    ////////////////////////////////////////////////////////////////////////////
    // Serial line: baud enable and shared open-drain drive.
    logic [15:0] bdiv_r;
    logic [15:0] bdiv_nxt;
    logic btick;

    // Free-running baud enable; the transmitter paces its bits on this pulse.
    always_comb begin
        btick = (bdiv_r == 16'(BAUD_DIV - 1));
        bdiv_nxt = btick ? 16'h0000 : bdiv_r + 16'h0001;
    end

    // Baud divider register.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            bdiv_r <= 16'h0000;
        end else begin
            bdiv_r <= bdiv_nxt;
        end
    end

    assign o_baud_tick = btick;
    // Only a low bit is driven; a high bit is left to the pull-up.
    assign o_serial_line = 1'b0;
    assign o_serial_line_oe_n = ~(i_tx_active & ~i_tx_bit);
    // Receive always watches the line, so our own bits come back.
    assign o_rx_bit = i_serial_line;

    ////////////////////////////////////////////////////////////////////////////
    // Circulating ring master.
    // The divider hands out launch and sample enables; nothing runs on a second clock.
    sbm_ring_if ring ();

    sbm_ring_clkgen u_clk (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_half_period(i_ring_half_period),
        .ring(ring.gen)
    );

    // Ring state: bit index, launched bit, frame sync and the received image.
    logic [5:0] bit_r;
    logic [5:0] bit_nxt;
    logic out_r;
    logic out_nxt;
    logic sync_r;
    logic sync_nxt;
    logic [39:0] sh_r;
    logic [39:0] sh_nxt;
    logic [39:0] pkt_r;
    logic [39:0] pkt_nxt;
    logic valid_r;
    logic valid_nxt;

    // Outgoing bit is our own when its index lies in our field, otherwise the
    // bit received at that index in the previous packet is sent again, which keeps others' bits intact.
    always_comb begin
        bit_nxt = bit_r;
        out_nxt = out_r;
        sync_nxt = sync_r;
        sh_nxt = sh_r;
        pkt_nxt = pkt_r;
        valid_nxt = 1'b0;
        if (ring.launch) begin
            bit_nxt = (bit_r == 6'(RING_BITS - 1)) ? 6'h00 : bit_r + 6'h01;
            sync_nxt = (bit_r == 6'(RING_BITS - 1));
            if (bit_nxt < 6'(sbm_pkg::RING_OWN_BITS)) begin
                out_nxt = i_ring_own_bits[bit_nxt[3:0]];
            end else begin
                out_nxt = sh_r[bit_nxt];
            end
        end
        if (ring.sample) begin
            sh_nxt[bit_r] = i_ring_data_in;
            if (bit_r == 6'(RING_BITS - 1)) begin
                pkt_nxt = sh_nxt;
                valid_nxt = 1'b1;
            end
        end
    end

    // Reset parks the index on the last bit so the first launch opens a packet.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            bit_r <= 6'h27;
            out_r <= 1'b0;
            sync_r <= 1'b0;
            sh_r <= 40'h0000000000;
            pkt_r <= 40'h0000000000;
            valid_r <= 1'b0;
        end else begin
            bit_r <= bit_nxt;
            out_r <= out_nxt;
            sync_r <= sync_nxt;
            sh_r <= sh_nxt;
            pkt_r <= pkt_nxt;
            valid_r <= valid_nxt;
        end
    end

    // Ring pins come straight from flops; data out and frame sync move only on launch edges.
    assign o_ring_bit_clock = ring.clk_level;
    assign o_ring_frame_sync = sync_r;
    assign o_ring_data_out = out_r;
    assign o_ring_packet = pkt_r;
    assign o_ring_packet_valid = valid_r;
endmodule : sbm_station_bus_master
`default_nettype wire

// *** sbm_pkg.sv ***
`default_nettype none
package sbm_pkg;
    // Processor bus clock and the figures derived from it.
    localparam int unsigned BUS_CLK_HZ = 1987200;
    localparam int unsigned STROBE_DIV = 640;
    localparam int unsigned STROBE_HZ = 3105;
    localparam int unsigned NIBBLE_COUNT = 16;
    localparam int unsigned NIBBLE_W = 4;
    localparam int unsigned NIBBLE_BUS_BITS = 64;
    localparam int unsigned SERIAL_BAUD = 1200;
    localparam int unsigned RING_BITS = 40;
    localparam int unsigned RING_OWN_BITS = 16;
    localparam int unsigned RING_OWN_LSB = 0;
    localparam int unsigned RING_TRUNK_BITS = 16;
    localparam int unsigned RING_SECURE_BITS = 8;
    // Default ring half period in bus clocks: bit clock is bus clock / 2.
    localparam int unsigned RING_HALF_DEFAULT = 1;
    localparam logic [7:0] RING_HALF_RESET = 8'h01;
    localparam int unsigned BAUD_DIV = (BUS_CLK_HZ + SERIAL_BAUD / 2) / SERIAL_BAUD;
    localparam logic [3:0] NIBBLE_ADDR_RESET = 4'h0;
endpackage : sbm_pkg
`default_nettype wire

// *** sbm_ring_if.sv ***
`default_nettype none
// Bit-level strobes shared between the ring master and its bit clock divider.
interface sbm_ring_if;
    logic launch;
    logic sample;
    logic clk_level;
    modport gen (output launch, output sample, output clk_level);
    modport use_side (input launch, input sample, input clk_level);
endinterface : sbm_ring_if
`default_nettype wire

// *** sbm_ring_clkgen.sv ***
`default_nettype none
// Divider for the ring bit clock: square wave, half period programmable.
module sbm_ring_clkgen (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_half_period,
    sbm_ring_if.gen ring
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic lvl_r;
    logic lvl_nxt;
    logic half_end;

    // A half period of zero is served as one so the clock never stalls.
    always_comb begin
        half_end = (cnt_r + 8'h01 >= ((i_half_period == 8'h00) ? 8'h01 : i_half_period));
        cnt_nxt = half_end ? 8'h00 : cnt_r + 8'h01;
        lvl_nxt = half_end ? ~lvl_r : lvl_r;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            cnt_r <= 8'h00;
            lvl_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            lvl_r <= lvl_nxt;
        end
    end

    // Launch on the rising edge, sample on the falling edge.
    assign ring.launch = half_end & ~lvl_r;
    assign ring.sample = half_end & lvl_r;
    assign ring.clk_level = lvl_r;
endmodule : sbm_ring_clkgen
`default_nettype wire

// *** sbm_station_bus_master_assertions.sv ***
`default_nettype none
// Port-level checker; step spacing follows the strobe divider parameter.
module sbm_station_bus_master_assertions #(
    parameter int unsigned STROBE_DIV = 640
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [3:0] o_nibble_address,
    input wire logic o_nibble_strobe_n,
    input wire logic o_nibble_service_irq_n,
    input wire logic [3:0] i_nibble_data_n,
    input wire logic [3:0] i_nibble_wr_data,
    input wire logic [3:0] i_nibble_wr_en,
    input wire logic [3:0] o_nibble_data_oe_n,
    input wire logic [3:0] o_nibble_rd_data,
    input wire logic i_tx_bit,
    input wire logic i_tx_active,
    input wire logic o_serial_line_oe_n,
    input wire logic [7:0] i_ring_half_period,
    input wire logic o_ring_bit_clock,
    input wire logic o_ring_frame_sync,
    input wire logic o_ring_data_out
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic [15:0] cnt_r;
    logic seen_r;
    // Cycles since the last step; the first period after reset is skipped.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            cnt_r <= 16'h0000;
            seen_r <= 1'h0;
        end else begin
            cnt_r <= o_nibble_service_irq_n ? cnt_r + 16'h0001 : 16'h0001;
            seen_r <= seen_r | !o_nibble_service_irq_n;
        end
    end
    addr_step_a: assert property ($changed(o_nibble_address) |->
        o_nibble_address == $past(o_nibble_address) + 4'h1) else $error("address skipped");
    irq_step_a: assert property ((!o_nibble_service_irq_n) == $changed(o_nibble_address))
        else $error("irq not tied to step");
    step_period_a: assert property (!o_nibble_service_irq_n && seen_r |->
        cnt_r == STROBE_DIV) else $error("step period wrong");
    strobe_rise_a: assert property ($rose(o_nibble_strobe_n) |-> !o_nibble_service_irq_n)
        else $error("strobe rose off step");
    strobe_half_a: assert property (seen_r && cnt_r == STROBE_DIV / 2 |->
        $fell(o_nibble_strobe_n)) else $error("strobe low half wrong");
    nibble_drive_a: assert property (o_nibble_data_oe_n ==
        ~(i_nibble_wr_en & i_nibble_wr_data)) else $error("nibble drive wrong");
    nibble_capture_a: assert property (!o_nibble_service_irq_n |->
        o_nibble_rd_data == ~$past(i_nibble_data_n)) else $error("nibble capture wrong");
    serial_drive_a: assert property (o_serial_line_oe_n == !(i_tx_active && !i_tx_bit))
        else $error("serial drive wrong");
    ring_toggle_a: assert property (i_ring_half_period == 8'h01 && !$past(i_rst, 2) |->
        $changed(o_ring_bit_clock)) else $error("ring clock stalled");
    ring_edge_a: assert property ($changed(o_ring_data_out) || $changed(o_ring_frame_sync)
        |-> $rose(o_ring_bit_clock)) else $error("ring data off edge");
    sync_width_a: assert property ($rose(o_ring_frame_sync) && i_ring_half_period == 8'h01
        |=> o_ring_frame_sync ##1 !o_ring_frame_sync) else $error("sync width wrong");
    frame_gap_a: assert property ($rose(o_ring_frame_sync) && i_ring_half_period == 8'h01
        |-> ##80 $rose(o_ring_frame_sync)) else $error("packet length wrong");
endmodule : sbm_station_bus_master_assertions
////////////////////////////////////////////////////////////////////////////////
bind sbm_station_bus_master sbm_station_bus_master_assertions #(.STROBE_DIV(STROBE_DIV)) u_chk (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .o_nibble_address(o_nibble_address),
    .o_nibble_strobe_n(o_nibble_strobe_n), .o_nibble_service_irq_n(o_nibble_service_irq_n),
    .i_nibble_data_n(i_nibble_data_n), .i_nibble_wr_data(i_nibble_wr_data),
    .i_nibble_wr_en(i_nibble_wr_en), .o_nibble_data_oe_n(o_nibble_data_oe_n),
    .o_nibble_rd_data(o_nibble_rd_data), .i_tx_bit(i_tx_bit), .i_tx_active(i_tx_active),
    .o_serial_line_oe_n(o_serial_line_oe_n), .i_ring_half_period(i_ring_half_period),
    .o_ring_bit_clock(o_ring_bit_clock), .o_ring_frame_sync(o_ring_frame_sync),
    .o_ring_data_out(o_ring_data_out));
`default_nettype wire

// *** sbm_far_station.sv ***
`default_nettype none
// The other station modules: nibble bus slaves and the rest of the ring.
module sbm_far_station (
    input wire logic [3:0] i_addr,
    input wire logic [63:0] i_nib_tab,
    input wire logic [23:0] i_far_bits,
    input wire logic i_ring_bit_clock,
    input wire logic i_ring_frame_sync,
    input wire logic i_ring_data_out,
    output logic [3:0] o_pull_n,
    output logic o_ring_data_in
);
    timeunit 1ns;
    timeprecision 100ps;
    int idx = 0;
    // Slaves pull the active-low lines of the presented nibble.
    assign o_pull_n = ~i_nib_tab[i_addr * 4 +: 4];
    // Bits move after the rising edge for reading on the falling one; the far
    // modules overwrite their own 24 bits and pass the master's 16 through.
    always @(posedge i_ring_bit_clock) begin
        #2;
        idx = i_ring_frame_sync ? 0 : idx + 1;
        o_ring_data_in = (idx < 16) ? i_ring_data_out : i_far_bits[idx - 16];
    end
endmodule : sbm_far_station
`default_nettype wire

// *** sbm_station_bus_master_bench.sv ***
`default_nettype none
module sbm_station_bus_master_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, strobe_n, irq_n, tx_bit, tx_act, ser_o, ser_oe_n, rx, baud;
    logic ring_clk, sync, rout, rin, pvalid;
    logic [3:0] addr, wr_data, wr_en, rd, oe_n, dout_n, pull_n;
    logic [15:0] own;
    logic [23:0] far;
    logic [39:0] pkt;
    logic [63:0] tab;
    logic [7:0] half;
    // Cycles since the last baud tick; negative until the first tick after reset.
    int bgap = -1;
    logic [39:0] nq[$], rq[$];
    int num_errors = 0, n_checks = 0;
    // Wired lines: pull-ups, low wherever any party drives.
    wire logic [3:0] ndata_n = pull_n & (oe_n | dout_n);
    wire logic ser = ser_oe_n | ser_o;
    sbm_station_bus_master #(.STROBE_DIV(8), .BAUD_DIV(4)) u_sbm_station_bus_master (
        .i_sys_clk(clk), .i_rst(rst), .o_nibble_address(addr), .o_nibble_strobe_n(strobe_n),
        .o_nibble_service_irq_n(irq_n), .i_nibble_data_n(ndata_n), .o_nibble_data_n(dout_n),
        .o_nibble_data_oe_n(oe_n), .i_nibble_wr_data(wr_data), .i_nibble_wr_en(wr_en),
        .o_nibble_rd_data(rd), .i_serial_line(ser), .o_serial_line(ser_o),
        .o_serial_line_oe_n(ser_oe_n), .i_tx_bit(tx_bit), .i_tx_active(tx_act), .o_rx_bit(rx),
        .o_baud_tick(baud), .i_ring_half_period(half), .i_ring_own_bits(own),
        .o_ring_bit_clock(ring_clk), .o_ring_frame_sync(sync), .o_ring_data_out(rout),
        .i_ring_data_in(rin), .o_ring_packet(pkt), .o_ring_packet_valid(pvalid));
    sbm_far_station u_sbm_far_station (.i_addr(addr), .i_nib_tab(tab), .i_far_bits(far),
        .i_ring_bit_clock(ring_clk), .i_ring_frame_sync(sync), .i_ring_data_out(rout),
        .o_pull_n(pull_n), .o_ring_data_in(rin));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    // Bounded wait for a step (0) or a packet (1); a hang ends the run.
    task automatic wait_for(input bit ring);
        for (int n = 0; n < 500; n++) begin
            @(posedge clk);
            #2;
            if (ring ? pvalid === 1'h1 : irq_n === 1'h0) return;
        end
        num_errors++;
        tally_and_finish();
    endtask : wait_for
    ////////////////////////////////////////////////////////////////////////////
    // The clock toggles every half period.
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    // Results are matched to the oldest note as they appear.
    always @(posedge clk) begin
        #1;
        if (irq_n === 1'h0 && nq.size() > 0) check({36'h0, rd}, nq.pop_front());
        if (pvalid === 1'h1 && rq.size() > 0) check(pkt, rq.pop_front());
        // The bench builds the block with a baud divider of four.
        if (rst === 1'h1) bgap = -1;
        else if (bgap >= 0) bgap++;
        if (baud === 1'h1) begin
            if (bgap > 0) check(40'(bgap), 40'h4);
            bgap = 0;
        end
    end
    // Main sequence: nibble scan, ring packets and serial traffic side by side.
    initial begin
        void'($urandom(32'h4F3E5467));
        {rst, tx_bit, tx_act, wr_data, wr_en} = {3'h6, 8'h00};
        own = 16'h0000;
        half = 8'h01;
        far = 24'h000000;
        tab = {$urandom, $urandom};
        repeat (12) @(posedge clk);
        #2;
        rst = 1'h0;
        fork
            for (int k = 0; k < 40; k++) begin
                wr_data = 4'($urandom);
                wr_en = 4'($urandom);
                nq.push_back({36'h0, tab[k % 16 * 4 +: 4] | (wr_en & wr_data)});
                wait_for(1'h0);
                check({36'h0, addr}, 40'((k + 1) % 16));
            end
            for (int k = 0; k < 6; k++) begin
                own = 16'($urandom);
                far = 24'($urandom);
                wait_for(1'h1);
                wait_for(1'h1);
                rq.push_back({far, own});
                wait_for(1'h1);
            end
            repeat (300) begin
                @(posedge clk);
                #2;
                {tx_bit, tx_act} = 2'($urandom);
                #1;
                check({39'h0, rx}, {39'h0, !(tx_act && !tx_bit)});
            end
        join
        // Mid-run reset with a slower ring clock: the scan restarts at nibble 0
        // and the first packet after release already carries the new bits.
        @(posedge clk);
        #2;
        rst = 1'h1;
        half = 8'h03;
        repeat (12) @(posedge clk);
        #2;
        rst = 1'h0;
        own = 16'($urandom);
        far = 24'($urandom);
        nq.push_back({36'h0, tab[3:0] | (wr_en & wr_data)});
        rq.push_back({far, own});
        wait_for(1'h0);
        check({36'h0, addr}, 40'h1);
        wait_for(1'h1);
        check(40'(nq.size() + rq.size()), 40'h0);
        tally_and_finish();
    end
endmodule : sbm_station_bus_master_bench
`default_nettype wire
